// >>> scc_pkg.sv
// Shared constants, encodings and register map of the smart card interface control block.
package scc_pkg;

    // Core clock and the card insertion debounce time.
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int DEBOUNCE_TIME_US = 8000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int DEB_W = 21;

    // Avalon-MM slave geometry and byte addresses.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CARD_STATE = 4'h8;

    // Interrupt event bits, shared by the status and mask registers.
    localparam int N_IRQ = 2;
    localparam int IRQ_PRESENT = 0;
    localparam int IRQ_OVERLOAD = 1;
    localparam logic [N_IRQ-1:0] IRQ_MASK_RESET = 2'h3;

    // Field positions of the read-only card state register.
    localparam int ST_PRESENT = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_LEVEL_LO = 2;
    localparam int ST_LEVEL_HI = 3;
    localparam int ST_UNDERVOLT = 4;
    localparam int ST_OVERLOAD = 5;

    // Bidirectional lanes: main data, first auxiliary (C4), second auxiliary (C8).
    localparam int N_LANE = 3;
    localparam int LANE_DATA = 0;
    localparam int LANE_AUX_A = 1;
    localparam int LANE_AUX_B = 2;

    typedef enum logic [1:0] {
        SUPPLY_OFF,
        SUPPLY_1V8,
        SUPPLY_3V,
        SUPPLY_5V
    } scc_supply_t;

    typedef enum logic [1:0] {
        DIV_BY_1,
        DIV_BY_2,
        DIV_BY_4,
        DIV_BY_8
    } scc_div_t;

    typedef enum logic {
        SESS_IDLE,
        SESS_ACTIVE
    } scc_sess_t;

    typedef enum logic [1:0] {
        LANE_IDLE,
        LANE_HOST_TO_CARD,
        LANE_CARD_TO_HOST,
        LANE_RELEASE
    } scc_lane_t;

endpackage

// >>> scc_div_if.sv
// Link between the control core and the card clock divider.
`timescale 1ns/1ps
interface scc_div_if;
    import scc_pkg::*;

    logic ext_clk;
    scc_div_t ratio;
    logic run;
    logic card_clk;

    modport ctrl (
        output ext_clk,
        output ratio,
        output run,
        input card_clk
    );

    modport div (
        input ext_clk,
        input ratio,
        input run,
        output card_clk
    );
endinterface

// >>> scc_clk_div.sv
// Card clock divider driven by the sampled external clock input.
`timescale 1ns/1ps
module scc_clk_div
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control side
    scc_div_if.div dif
);

    typedef struct packed {
        logic ext_prev;
        logic [2:0] cnt;
        logic card_clk;
    } scc_div_state_t;

    scc_div_state_t q;
    scc_div_state_t d;

    always_comb begin
        d = q;
        d.ext_prev = dif.ext_clk;
        if (!dif.run) begin
            // Stopped clock parks low so the card sees no stray edge.
            d.cnt = 3'h0;
            d.card_clk = 1'b0;
        end else begin
            if (dif.ext_clk && !q.ext_prev) begin
                d.cnt = q.cnt + 3'h1;
            end
            case (dif.ratio)
                DIV_BY_1: d.card_clk = dif.ext_clk;
                DIV_BY_2: d.card_clk = d.cnt[0];
                DIV_BY_4: d.card_clk = d.cnt[1];
                DIV_BY_8: d.card_clk = d.cnt[2];
                default: d.card_clk = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dif.card_clk = q.card_clk;

endmodule

// >>> scc_ctrl.sv
// Smart card interface control: session sequencing, presence, faults, lanes and registers.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module scc_ctrl
    import scc_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES_P = DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM register slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Host control pins
    input wire logic card_supply_select_a_i,
    input wire logic card_supply_select_b_i,
    input wire logic supply_command_n_i,
    input wire logic host_reset_input_i,
    input wire logic divider_select_a_i,
    input wire logic divider_select_b_i,
    input wire logic external_clock_input_i,
    output logic int_n_o,
    // Presence and supply monitors
    input wire logic card_presence_n_i,
    input wire logic card_presence_i,
    input wire logic supply_overload_i,
    input wire logic vdd_undervoltage_i,
    // Card outputs
    output logic [1:0] card_supply_output_o,
    output logic card_reset_output_o,
    output logic card_clock_output_o,
    // Host-side lanes: data, aux line a, aux line b
    input wire logic [N_LANE-1:0] host_line_i,
    output logic [N_LANE-1:0] host_line_o,
    output logic [N_LANE-1:0] host_line_oe_o,
    // Card-side lanes: data, C4, C8
    input wire logic [N_LANE-1:0] card_line_i,
    output logic [N_LANE-1:0] card_line_o,
    output logic [N_LANE-1:0] card_line_oe_o
);

    localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES_P - 1);

    typedef struct packed {
        scc_sess_t sess;
        logic cmd_prev;
        logic [DEB_W-1:0] deb_cnt;
        logic present;
        logic ovl_prev;
        logic [N_IRQ-1:0] irq_status;
        logic [N_IRQ-1:0] irq_mask;
        logic int_n;
        logic wait_req;
        logic [DATA_W-1:0] rdata;
        scc_supply_t supply;
        logic card_rst;
        scc_lane_t [N_LANE-1:0] lane;
        logic [N_LANE-1:0] host_oe;
        logic [N_LANE-1:0] card_oe;
    } scc_ctrl_state_t;

    scc_ctrl_state_t q;
    scc_ctrl_state_t d;

    scc_div_if dif ();

    scc_clk_div u_clk_div (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .dif (dif)
    );

    // Lane direction step. The side that pulled the lane low owns it until it lets go,
    // so our own drive, echoed back on the other pin, cannot flip the direction.
    function automatic scc_lane_t lane_step(
        input scc_lane_t cur,
        input logic host_lvl,
        input logic card_lvl,
        input logic en
    );
        scc_lane_t nxt;
        nxt = cur;
        if (!en) begin
            nxt = LANE_IDLE;
        end else begin
            case (cur)
                LANE_IDLE: begin
                    if (!host_lvl) begin
                        nxt = LANE_HOST_TO_CARD;
                    end else if (!card_lvl) begin
                        nxt = LANE_CARD_TO_HOST;
                    end
                end
                LANE_HOST_TO_CARD: begin
                    if (host_lvl) begin
                        nxt = LANE_RELEASE;
                    end
                end
                LANE_CARD_TO_HOST: begin
                    if (card_lvl) begin
                        nxt = LANE_RELEASE;
                    end
                end
                LANE_RELEASE: begin
                    // Wait for both pins to float high before sensing again.
                    if (host_lvl && card_lvl) begin
                        nxt = LANE_IDLE;
                    end
                end
                default: nxt = LANE_IDLE;
            endcase
        end
        return nxt;
    endfunction

    logic present_raw;
    logic cmd_fall;
    logic ovl_rise;
    logic present_rise;
    logic lanes_en;
    logic req;
    logic accept_wr;
    logic [N_IRQ-1:0] irq_set;
    logic [N_IRQ-1:0] irq_clr;
    logic [DATA_W-1:0] rd_mux;
    scc_supply_t sel_level;
    scc_lane_t [N_LANE-1:0] lane_next;

    assign present_raw = ~card_presence_n_i | card_presence_i;
    assign cmd_fall = q.cmd_prev & ~supply_command_n_i;
    assign ovl_rise = supply_overload_i & ~q.ovl_prev;
    assign lanes_en = (q.sess == SESS_ACTIVE) & ~vdd_undervoltage_i;
    assign req = avs_read_i | avs_write_i;
    assign accept_wr = avs_write_i & ~q.wait_req;

    for (genvar i = 0; i < N_LANE; i++) begin : g_lane
        // Lane 0 is the main data lane, 1 and 2 the auxiliaries; all behave alike.
        assign lane_next[i] = lane_step(q.lane[i], host_line_i[i], card_line_i[i],
            lanes_en);
    end

    always_comb begin
        case ({card_supply_select_a_i, card_supply_select_b_i})
            2'h0: sel_level = SUPPLY_3V;
            2'h1: sel_level = SUPPLY_5V;
            2'h2: sel_level = SUPPLY_3V;
            2'h3: sel_level = SUPPLY_1V8;
            default: sel_level = SUPPLY_3V;
        endcase
    end

    always_comb begin
        rd_mux = '0;
        case (avs_address_i)
            REG_IRQ_STATUS: rd_mux[N_IRQ-1:0] = q.irq_status;
            REG_IRQ_MASK: rd_mux[N_IRQ-1:0] = q.irq_mask;
            REG_CARD_STATE: begin
                rd_mux[ST_PRESENT] = q.present;
                rd_mux[ST_ACTIVE] = q.sess == SESS_ACTIVE;
                rd_mux[ST_LEVEL_HI:ST_LEVEL_LO] = q.supply;
                rd_mux[ST_UNDERVOLT] = vdd_undervoltage_i;
                rd_mux[ST_OVERLOAD] = supply_overload_i;
            end
            default: rd_mux = '0;
        endcase
    end

    always_comb begin
        d = q;
        present_rise = 1'b0;

        // Removal is honoured at once; only insertion is debounced.
        if (!present_raw) begin
            d.deb_cnt = '0;
            d.present = 1'b0;
        end else if (!q.present) begin
            if (q.deb_cnt == DEB_LAST) begin
                d.present = 1'b1;
                present_rise = 1'b1;
            end else begin
                d.deb_cnt = q.deb_cnt + 1'b1;
            end
        end

        d.cmd_prev = supply_command_n_i;
        d.ovl_prev = supply_overload_i;

        case (q.sess)
            SESS_IDLE: begin
                if (cmd_fall && q.present && !vdd_undervoltage_i && !supply_overload_i) begin
                    d.sess = SESS_ACTIVE;
                end
            end
            SESS_ACTIVE: begin
                // A high command, card loss, overload or low controller supply all end it.
                if (supply_command_n_i || !present_raw || supply_overload_i
                        || vdd_undervoltage_i) begin
                    d.sess = SESS_IDLE;
                end
            end
            default: d.sess = SESS_IDLE;
        endcase

        if (d.sess == SESS_ACTIVE) begin
            d.supply = sel_level;
            d.card_rst = host_reset_input_i;
        end else begin
            d.supply = SUPPLY_OFF;
            d.card_rst = 1'b0;
        end

        for (int i = 0; i < N_LANE; i++) begin
            d.lane[i] = lane_next[i];
            d.card_oe[i] = lane_next[i] == LANE_HOST_TO_CARD;
            d.host_oe[i] = lane_next[i] == LANE_CARD_TO_HOST;
        end

        irq_set = '0;
        irq_set[IRQ_PRESENT] = present_rise;
        irq_set[IRQ_OVERLOAD] = ovl_rise;
        irq_clr = '0;
        if (accept_wr && avs_address_i == REG_IRQ_STATUS && avs_byteenable_i[0]) begin
            irq_clr = avs_writedata_i[N_IRQ-1:0];
        end
        if (accept_wr && avs_address_i == REG_IRQ_MASK && avs_byteenable_i[0]) begin
            d.irq_mask = avs_writedata_i[N_IRQ-1:0];
        end
        // A new event in the clearing cycle survives the clear.
        d.irq_status = (q.irq_status & ~irq_clr) | irq_set;
        d.int_n = ~|(d.irq_status & d.irq_mask);

        // Every access is answered one cycle after it is first seen.
        if (req && q.wait_req) begin
            d.wait_req = 1'b0;
            d.rdata = avs_read_i ? rd_mux : '0;
        end else begin
            d.wait_req = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.cmd_prev <= 1'b1;
            q.int_n <= 1'b1;
            q.wait_req <= 1'b1;
            q.irq_mask <= IRQ_MASK_RESET;
        end else begin
            q <= d;
        end
    end

    // Divider runs only in a session, so the card clock is parked low otherwise.
    assign dif.ext_clk = external_clock_input_i;
    assign dif.ratio = scc_div_t'({divider_select_b_i, divider_select_a_i});
    assign dif.run = q.sess == SESS_ACTIVE;

    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.wait_req;
    assign int_n_o = q.int_n;
    assign card_supply_output_o = q.supply;
    assign card_reset_output_o = q.card_rst;
    assign card_clock_output_o = dif.card_clk;
    assign host_line_oe_o = q.host_oe;
    assign card_line_oe_o = q.card_oe;
    // Lanes are open-drain style: only a low is ever driven.
    assign host_line_o = '0;
    assign card_line_o = '0;

endmodule

// >>> scc_ctrl_properties.sv
// Port-level assertions for the smart card interface control block.
`timescale 1ns/1ps
module scc_ctrl_properties
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_waitrequest_o,
    // Host control and monitors
    input wire logic card_supply_select_a_i,
    input wire logic card_supply_select_b_i,
    input wire logic supply_command_n_i,
    input wire logic supply_overload_i,
    input wire logic vdd_undervoltage_i,
    input wire logic int_n_o,
    // Card side and lanes
    input wire logic [1:0] card_supply_output_o,
    input wire logic card_reset_output_o,
    input wire logic card_clock_output_o,
    input wire logic [N_LANE-1:0] host_line_i,
    input wire logic [N_LANE-1:0] host_line_oe_o,
    input wire logic [N_LANE-1:0] card_line_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic act;
    logic [N_IRQ-1:0] mask_q;
    assign act = card_supply_output_o != 2'h0;
    // The mask is shadowed from bus writes so the interrupt checks know what may fire.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= IRQ_MASK_RESET;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_IRQ_MASK
                && avs_byteenable_i[0]) begin
            mask_q <= avs_writedata_i[N_IRQ-1:0];
        end
    end
    function automatic logic [1:0] level_f(input logic sa, input logic sb);
        return sb ? (sa ? 2'h1 : 2'h3) : 2'h2;
    endfunction
    sequence bus_req_s;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence bus_ack_s;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    property lane_p(int k);
        card_line_oe_o[k] |-> !$past(host_line_i[k]) && !host_line_oe_o[k];
    endproperty
    bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
        else $error("bus answer missing");
    supply_code_a: assert property (act && $past(act) |->
        card_supply_output_o == level_f($past(card_supply_select_a_i),
        $past(card_supply_select_b_i))) else $error("supply code wrong");
    session_start_a: assert property ($rose(act) |-> !$past(supply_command_n_i) &&
        ($past(supply_command_n_i, 2) || $past(supply_command_n_i, 3)))
        else $error("session began without command fall");
    undervolt_off_a: assert property (vdd_undervoltage_i [*3] |->
        !act && card_line_oe_o == '0 && host_line_oe_o == '0) else $error("pins on in undervolt");
    idle_pins_a: assert property (!act [*3] |-> !card_reset_output_o &&
        !card_clock_output_o && card_line_oe_o == '0) else $error("card pins busy while idle");
    data_lane_a: assert property (lane_p(LANE_DATA))
        else $error("data lane drive without host low");
    aux_c4_lane_a: assert property (lane_p(LANE_AUX_A))
        else $error("C4 lane drive without host low");
    aux_c8_lane_a: assert property (lane_p(LANE_AUX_B))
        else $error("C8 lane drive without host low");
    overload_irq_a: assert property ($rose(supply_overload_i) && mask_q[IRQ_OVERLOAD]
        |-> ##[1:3] !int_n_o) else $error("overload raised no interrupt");
    masked_quiet_a: assert property (mask_q == '0 && $past(mask_q) == '0 |-> int_n_o)
        else $error("interrupt with all events masked");
endmodule
bind scc_ctrl scc_ctrl_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_waitrequest_o(avs_waitrequest_o), .card_supply_select_a_i(card_supply_select_a_i),
    .card_supply_select_b_i(card_supply_select_b_i), .supply_command_n_i(supply_command_n_i),
    .supply_overload_i(supply_overload_i), .vdd_undervoltage_i(vdd_undervoltage_i),
    .int_n_o(int_n_o), .card_supply_output_o(card_supply_output_o),
    .card_reset_output_o(card_reset_output_o), .card_clock_output_o(card_clock_output_o),
    .host_line_i(host_line_i), .host_line_oe_o(host_line_oe_o),
    .card_line_oe_o(card_line_oe_o));

// >>> scc_card_model.sv
// Behavioural smart card contacts on the three open-drain lanes.
`timescale 1ns/1ps
module scc_card_model
    import scc_pkg::*;
(
    // Drive from the device and from the card, high pulls the contact low
    input wire logic [N_LANE-1:0] card_line_oe_i,
    input wire logic [N_LANE-1:0] drive_low_i,
    // Resolved contact level
    output logic [N_LANE-1:0] line_o
);
    // A released contact rises through its pull-up, never keeping the last level.
    assign line_o = ~(card_line_oe_i | drive_low_i);
endmodule

// >>> scc_ctrl_tb.sv
// Self-checking testbench of the smart card interface control block.
`timescale 1ns/1ps
module scc_ctrl_tb;
    import scc_pkg::*;
    localparam int DEB = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] adr = 4'h0;
    logic rd = 1'b0, wr = 1'b0, wreq, int_n, card_rst, card_clk, prev;
    logic [DATA_W-1:0] wdat = 32'h0, rdat, got;
    logic sel_a = 1'b0, sel_b = 1'b0, cmd_n = 1'b1, hrst = 1'b0, ext_clk = 1'b0;
    logic card_presence_input_n = 1'b1, card_presence_input = 1'b0, ovl = 1'b0, uv = 1'b0;
    logic [N_LANE-1:0] host_drv = '0, card_drv = '0, host_lvl, card_lvl, host_oe, card_oe;
    logic [1:0] supply;
    logic [3:0] be = 4'hF;
    logic [N_LANE-1:0] host_dat, card_dat;
    int err_total = 0;
    int checks = 0;
    int n;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) ext_clk <= ~ext_clk;
    // Host lines carry pull-ups, so a released lane reads high.
    assign host_lvl = ~(host_drv | host_oe);
    scc_ctrl #(.DEBOUNCE_CYCLES_P(DEB)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .card_supply_select_a_i(sel_a), .card_supply_select_b_i(sel_b),
        .supply_command_n_i(cmd_n), .host_reset_input_i(hrst), .divider_select_a_i(sel_a),
        .divider_select_b_i(sel_b), .external_clock_input_i(ext_clk), .int_n_o(int_n),
        .card_presence_n_i(card_presence_input_n), .card_presence_i(card_presence_input), .supply_overload_i(ovl),
        .vdd_undervoltage_i(uv), .card_supply_output_o(supply), .card_reset_output_o(card_rst),
        .card_clock_output_o(card_clk), .host_line_i(host_lvl), .host_line_o(host_dat),
        .host_line_oe_o(host_oe), .card_line_i(card_lvl), .card_line_o(card_dat),
        .card_line_oe_o(card_oe));
    scc_card_model u_card (.card_line_oe_i(card_oe), .drive_low_i(card_drv), .line_o(card_lvl));
    task automatic wt(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // The request stands until waitrequest is sampled low; data is taken at that edge.
    // Only the watchdog ends a wait that never sees waitrequest low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (wreq !== 1'b0) begin
            @(posedge clk_i);
        end
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0);
        chk(name, got, exp);
    endtask
    function automatic logic [1:0] lvl_f(input int i);
        return i[1] ? (i[0] ? 2'h1 : 2'h3) : 2'h2;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        wt(20);
        rst_i <= 1'b0;
        wt(1);
        rchk(REG_IRQ_STATUS, 32'h0, "status_reset");
        rchk(REG_IRQ_MASK, 32'h3, "mask_reset");
        // A write without its low byte lane enabled must leave the mask alone.
        be <= 4'hE;
        bus(1'b1, REG_IRQ_MASK, 32'h0);
        be <= 4'hF;
        rchk(REG_IRQ_MASK, 32'h3, "mask_byte_off");
        bus(1'b1, REG_CARD_STATE, 32'h3F);
        rchk(REG_CARD_STATE, 32'h0, "state_readonly");
        rchk(4'hC, 32'h0, "unmapped");
        chk("int_idle", int_n, 1'b1);
        // The command is already low when the card arrives, so no session may start.
        cmd_n <= 1'b0;
        card_presence_input_n <= 1'b0;
        wt(DEB / 2);
        chk("int_debounce", int_n, 1'b1);
        wt(DEB + 4);
        chk("int_present", int_n, 1'b0);
        chk("no_session", supply, 2'h0);
        rchk(REG_IRQ_STATUS, 32'h1, "status_present");
        rchk(REG_CARD_STATE, 32'h1, "state_present");
        bus(1'b1, REG_IRQ_STATUS, 32'h1);
        chk("int_cleared", int_n, 1'b1);
        // The card is pulled first, so the active-high input gives a fresh insertion.
        cmd_n <= 1'b1;
        card_presence_input_n <= 1'b1;
        wt(2);
        rchk(REG_CARD_STATE, 32'h0, "state_removed");
        card_presence_input <= 1'b1;
        wt(DEB + 4);
        rchk(REG_IRQ_STATUS, 32'h1, "status_present_high");
        bus(1'b1, REG_IRQ_STATUS, 32'h1);
        for (int i = 0; i < 4; i++) begin
            sel_a <= i[0];
            sel_b <= i[1];
            hrst <= 1'b0;
            wt(2);
            cmd_n <= 1'b0;
            wt(4);
            chk("supply", supply, lvl_f(i));
            rchk(REG_CARD_STATE, 32'({lvl_f(i), 2'h3}), "state_active");
            hrst <= 1'b1;
            wt(3);
            chk("card_reset", card_rst, 1'b1);
            n = 0;
            prev = card_clk;
            repeat (64) begin
                @(posedge clk_i);
                if (card_clk && !prev) n++;
                prev = card_clk;
            end
            chk("clock_ratio", n >= (32 >> i) - 1 && n <= (32 >> i) + 1, 1'b1);
            cmd_n <= 1'b1;
            wt(3);
            chk("supply_off", supply, 2'h0);
            chk("reset_idle", {card_rst, card_clk}, 2'h0);
        end
        cmd_n <= 1'b0;
        wt(4);
        for (int k = 0; k < N_LANE; k++) begin
            host_drv[k] <= 1'b1;
            wt(2);
            chk("card_lane", {card_oe[k], card_lvl[k]}, 2'h2);
            chk("lane_low", {host_dat[k], card_dat[k]}, 2'h0);
            host_drv[k] <= 1'b0;
            wt(3);
            card_drv[k] <= 1'b1;
            wt(2);
            chk("host_lane", {host_oe[k], host_lvl[k], card_oe[k]}, 3'h4);
            card_drv[k] <= 1'b0;
            wt(3);
            chk("lane_idle", {host_oe[k], card_oe[k]}, 2'h0);
        end
        bus(1'b1, REG_IRQ_MASK, 32'h2);
        ovl <= 1'b1;
        wt(4);
        chk("overload", {supply, int_n}, 3'h0);
        rchk(REG_IRQ_STATUS, 32'h2, "status_overload");
        rchk(REG_CARD_STATE, 32'h21, "state_overload");
        ovl <= 1'b0;
        bus(1'b1, REG_IRQ_STATUS, 32'h2);
        chk("int_released", int_n, 1'b1);
        bus(1'b1, REG_IRQ_MASK, 32'h0);
        ovl <= 1'b1;
        wt(4);
        ovl <= 1'b0;
        wt(2);
        chk("int_masked", int_n, 1'b1);
        rchk(REG_IRQ_STATUS, 32'h2, "status_masked");
        bus(1'b1, REG_IRQ_STATUS, 32'h2);
        bus(1'b1, REG_IRQ_MASK, 32'h3);
        cmd_n <= 1'b1;
        wt(2);
        cmd_n <= 1'b0;
        wt(4);
        chk("session_again", supply, lvl_f(3));
        uv <= 1'b1;
        host_drv <= 3'h7;
        wt(4);
        chk("undervolt_pins", {supply, card_oe, card_rst, card_clk}, 7'h0);
        cmd_n <= 1'b1;
        wt(2);
        cmd_n <= 1'b0;
        wt(4);
        chk("undervolt_start", supply, 2'h0);
        rchk(REG_CARD_STATE, 32'h11, "state_undervolt");
        uv <= 1'b0;
        host_drv <= '0;
        cmd_n <= 1'b1;
        wt(2);
        results();
    end
    initial begin
        wt(20000);
        err_total++;
        results();
    end
endmodule
